// ===== src/can_rx_element_packer.sv
// Added by the designer: strobed register access and the address map.
module can_rx_element_packer (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic rxSof,
  input wire logic [15:0] tsValue,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic rxAccept,
  input wire logic rxEsi,
  input wire logic rxExtendedId,
  input wire logic rxRtr,
  input wire logic rxR1,
  input wire logic [28:0] rxId,
  input wire logic rxEdl,
  input wire logic rxBrs,
  input wire logic [3:0] rxDlc,
  input wire logic rxUnmatched,
  input wire logic [6:0] rxFilterIdx,
  input wire logic [1:0] rxDest,
  input wire logic [5:0] rxIndex,
  output logic ramWe,
  output logic [13:0] ramAddr,
  output logic [31:0] ramWdata,
  output logic elementStored,
  output logic [1:0] storedDest,
  output logic [5:0] storedIndex,
  output logic busy
);
  can_rx_pkg::pack_state_t state;
  logic [2:0] sizeFifo0;
  logic [2:0] sizeFifo1;
  logic [2:0] sizeBuf;
  logic [13:0] startBuf;
  logic [13:0] startFifo0;
  logic [13:0] startFifo1;
  logic dropFlag;
  logic [7:0] storedCount;
  logic [6:0] lastBytes;
  logic [15:0] sofStamp;
  logic [6:0] byteCount;
  logic [31:0] bufWord;
  logic [3:0] dataIdx;
  logic lastIssued;
  logic acceptNow;
  logic dropNow;

  logic hdrEsi;
  logic hdrExtendedId;
  logic hdrRtrBit;
  logic [28:0] hdrId;
  logic hdrUnmatched;
  logic [6:0] hdrFilterIdx;
  logic hdrEdl;
  logic hdrBrs;
  logic [3:0] hdrDlc;
  logic [15:0] hdrStamp;
  can_rx_pkg::dest_t hdrDest;
  logic [5:0] hdrIndex;
  logic [2:0] hdrSize;

  logic [31:0] word0;
  logic [31:0] word1;
  logic [13:0] sectionStart;
  logic [11:0] elemOffset;
  logic [13:0] elemBase;

  rx_len_if lenBus ();

  can_rx_len_decode lenDecode (
    .lenBus(lenBus)
  );

  assign lenBus.dlc = hdrDlc;
  assign lenBus.fdFrame = hdrEdl;
  assign lenBus.sizeCode = hdrSize;

  assign busy = (state != can_rx_pkg::ST_IDLE);
  assign acceptNow = rxAccept && !busy && (rxDest != 2'b11);
  assign dropNow = rxAccept && !acceptNow;

  // Register writes: element sizes and section start word addresses.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sizeFifo0 <= can_rx_pkg::ESZ_RST;
      sizeFifo1 <= can_rx_pkg::ESZ_RST;
      sizeBuf <= can_rx_pkg::ESZ_RST;
      startBuf <= can_rx_pkg::START_RST;
      startFifo0 <= can_rx_pkg::START_RST;
      startFifo1 <= can_rx_pkg::START_RST;
    end else if (regWrStb) begin
      unique case (regAddr)
        can_rx_pkg::OFS_ELEM_SIZE: begin
          sizeFifo0 <= regWrData[can_rx_pkg::ESZ_FIFO0_LSB +: 3];
          sizeFifo1 <= regWrData[can_rx_pkg::ESZ_FIFO1_LSB +: 3];
          sizeBuf <= regWrData[can_rx_pkg::ESZ_BUF_LSB +: 3];
        end
        can_rx_pkg::OFS_BUF_START: begin
          startBuf <= regWrData[can_rx_pkg::START_LSB +: 14];
        end
        can_rx_pkg::OFS_FIFO0_START: begin
          startFifo0 <= regWrData[can_rx_pkg::START_LSB +: 14];
        end
        can_rx_pkg::OFS_FIFO1_START: begin
          startFifo1 <= regWrData[can_rx_pkg::START_LSB +: 14];
        end
        default: begin
        end
      endcase
    end
  end

  // A dropped frame sets the flag even in the cycle software clears it.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dropFlag <= 1'b0;
    end else if (dropNow) begin
      dropFlag <= 1'b1;
    end else if (regWrStb && regAddr == can_rx_pkg::OFS_STATUS &&
                 regWrData[can_rx_pkg::ST_DROP]) begin
      dropFlag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      regRdData <= 32'h00000000;
    end else if (regRdStb) begin
      regRdData <= 32'h00000000;
      unique case (regAddr)
        can_rx_pkg::OFS_ELEM_SIZE: begin
          regRdData[can_rx_pkg::ESZ_FIFO0_LSB +: 3] <= sizeFifo0;
          regRdData[can_rx_pkg::ESZ_FIFO1_LSB +: 3] <= sizeFifo1;
          regRdData[can_rx_pkg::ESZ_BUF_LSB +: 3] <= sizeBuf;
        end
        can_rx_pkg::OFS_BUF_START: begin
          regRdData[can_rx_pkg::START_LSB +: 14] <= startBuf;
        end
        can_rx_pkg::OFS_FIFO0_START: begin
          regRdData[can_rx_pkg::START_LSB +: 14] <= startFifo0;
        end
        can_rx_pkg::OFS_FIFO1_START: begin
          regRdData[can_rx_pkg::START_LSB +: 14] <= startFifo1;
        end
        can_rx_pkg::OFS_STATUS: begin
          regRdData[can_rx_pkg::ST_BUSY] <= busy;
          regRdData[can_rx_pkg::ST_DROP] <= dropFlag;
          regRdData[can_rx_pkg::ST_DEST_LSB +: 2] <= storedDest;
          regRdData[can_rx_pkg::ST_INDEX_LSB +: 6] <= storedIndex;
          regRdData[can_rx_pkg::ST_COUNT_LSB +: 8] <= storedCount;
          regRdData[can_rx_pkg::ST_BYTES_LSB +: 7] <= lastBytes;
        end
        default: begin
        end
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end

  // Timestamp is taken at start of frame, not at acceptance.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sofStamp <= 16'h0000;
    end else if (rxSof) begin
      sofStamp <= tsValue;
    end
  end

  // Bytes past 64 are ignored. A new frame may refill the lanes only
  // as its bytes arrive, even while the previous element is still being written out.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      byteCount <= 7'h00;
    end else if (rxSof) begin
      byteCount <= 7'h00;
    end else if (rxByteValid && byteCount < can_rx_pkg::MAX_DATA_BYTES) begin
      byteCount <= byteCount + 7'h01;
    end
  end

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : gLane
      logic [7:0] laneMem [0:can_rx_pkg::MAX_DATA_WORDS-1];
      always_ff @(posedge mclk) begin
        if (rxByteValid && byteCount < can_rx_pkg::MAX_DATA_BYTES &&
            byteCount[1:0] == 2'(lane)) begin
          laneMem[byteCount[5:2]] <= rxByte;
        end
      end
      assign bufWord[lane*8 +: 8] = laneMem[dataIdx];
    end
  endgenerate

  // Frame fields are held for the whole element write.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hdrEsi <= 1'b0;
      hdrExtendedId <= 1'b0;
      hdrRtrBit <= 1'b0;
      hdrId <= 29'h00000000;
      hdrUnmatched <= 1'b0;
      hdrFilterIdx <= 7'h00;
      hdrEdl <= 1'b0;
      hdrBrs <= 1'b0;
      hdrDlc <= 4'h0;
      hdrStamp <= 16'h0000;
      hdrDest <= can_rx_pkg::DEST_BUF;
      hdrIndex <= 6'h00;
      hdrSize <= can_rx_pkg::ESZ_RST;
    end else if (acceptNow) begin
      hdrEsi <= rxEsi;
      hdrExtendedId <= rxExtendedId;
      hdrRtrBit <= rxEdl ? rxR1 : rxRtr;
      hdrId <= rxExtendedId ? rxId : {rxId[10:0], 18'h00000};
      hdrUnmatched <= rxUnmatched;
      hdrFilterIdx <= rxFilterIdx;
      hdrEdl <= rxEdl;
      hdrBrs <= rxBrs;
      hdrDlc <= rxDlc;
      hdrStamp <= sofStamp;
      hdrDest <= can_rx_pkg::dest_t'(rxDest);
      hdrIndex <= rxIndex;
      unique case (can_rx_pkg::dest_t'(rxDest))
        can_rx_pkg::DEST_FIFO0: hdrSize <= sizeFifo0;
        can_rx_pkg::DEST_FIFO1: hdrSize <= sizeFifo1;
        default: hdrSize <= sizeBuf;
      endcase
    end
  end

  always_comb begin
    word0 = 32'h00000000;
    word0[can_rx_pkg::W0_ESI] = hdrEsi;
    word0[can_rx_pkg::W0_EXT_ID] = hdrExtendedId;
    word0[can_rx_pkg::W0_RTR] = hdrRtrBit;
    word0[28:0] = hdrId;
    word1 = 32'h00000000;
    word1[can_rx_pkg::W1_UNMATCHED] = hdrUnmatched;
    word1[can_rx_pkg::W1_FILTER_LSB +: 7] = hdrFilterIdx;
    word1[can_rx_pkg::W1_EDL] = hdrEdl;
    word1[can_rx_pkg::W1_BRS] = hdrBrs;
    word1[can_rx_pkg::W1_DLC_LSB +: 4] = hdrDlc;
    word1[15:0] = hdrStamp;
  end

  always_comb begin
    unique case (hdrDest)
      can_rx_pkg::DEST_FIFO0: sectionStart = startFifo0;
      can_rx_pkg::DEST_FIFO1: sectionStart = startFifo1;
      default: sectionStart = startBuf;
    endcase
    elemOffset = hdrIndex * (7'(can_rx_pkg::HEADER_WORDS) +
                             7'(lenBus.dataWords));
    elemBase = sectionStart + 14'(elemOffset);
  end

  // Every configured data word is written; past the length it is stale.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= can_rx_pkg::ST_IDLE;
      ramWe <= 1'b0;
      ramAddr <= 14'h0000;
      ramWdata <= 32'h00000000;
      dataIdx <= 4'h0;
      lastIssued <= 1'b0;
    end else begin
      lastIssued <= 1'b0;
      unique case (state)
        can_rx_pkg::ST_IDLE: begin
          ramWe <= 1'b0;
          if (acceptNow) begin
            state <= can_rx_pkg::ST_WORD0;
          end
        end
        can_rx_pkg::ST_WORD0: begin
          ramWe <= 1'b1;
          ramAddr <= elemBase;
          ramWdata <= word0;
          dataIdx <= 4'h0;
          state <= can_rx_pkg::ST_WORD1;
        end
        can_rx_pkg::ST_WORD1: begin
          ramAddr <= ramAddr + 14'h0001;
          ramWdata <= word1;
          state <= can_rx_pkg::ST_DATA;
        end
        can_rx_pkg::ST_DATA: begin
          ramAddr <= ramAddr + 14'h0001;
          ramWdata <= bufWord;
          dataIdx <= dataIdx + 4'h1;
          if (5'(dataIdx) == lenBus.dataWords - 5'h01) begin
            state <= can_rx_pkg::ST_IDLE;
            lastIssued <= 1'b1;
          end
        end
      endcase
    end
  end

  // Report only after the final word has been taken by the memory.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      elementStored <= 1'b0;
      storedDest <= 2'h0;
      storedIndex <= 6'h00;
      storedCount <= 8'h00;
      lastBytes <= 7'h00;
    end else begin
      elementStored <= lastIssued;
      if (lastIssued) begin
        storedDest <= hdrDest;
        storedIndex <= hdrIndex;
        storedCount <= storedCount + 8'h01;
        lastBytes <= lenBus.dataBytes;
      end
    end
  end

  logic [4:0] wrCount;
  always_ff @(posedge mclk) begin
    if (!resetn || acceptNow) begin
      wrCount <= 5'h00;
    end else if (ramWe) begin
      wrCount <= wrCount + 5'h01;
    end
  end

  sequence SEQ_ACCEPT;
    rxAccept && !busy && rxDest != 2'b11;
  endsequence

  sequence SEQ_HDR0;
    ##2 ramWe;
  endsequence

  AST_W0_ESI: assert property (@(posedge mclk) disable iff (!resetn)
    SEQ_ACCEPT |-> SEQ_HDR0 ##0 ramWdata[31] == $past(rxEsi, 2))
    else $error("word 0 error state bit wrong");
  AST_W0_EXT_ID: assert property (@(posedge mclk) disable iff (!resetn)
    SEQ_ACCEPT |-> SEQ_HDR0 ##0 ramWdata[30] == $past(rxExtendedId, 2))
    else $error("word 0 extended flag wrong");
  AST_W0_RTR: assert property (@(posedge mclk) disable iff (!resetn)
    SEQ_ACCEPT |-> SEQ_HDR0 ##0 ramWdata[29] ==
      ($past(rxEdl, 2) ? $past(rxR1, 2) : $past(rxRtr, 2)))
    else $error("word 0 remote bit wrong");
  AST_STD_ID: assert property (@(posedge mclk) disable iff (!resetn)
    SEQ_ACCEPT and !rxExtendedId |-> SEQ_HDR0 ##0 ramWdata[17:0] == 18'h00000 &&
      ramWdata[28:18] == $past(rxId[10:0], 2))
    else $error("standard identifier misplaced");
  AST_W1_MATCH: assert property (@(posedge mclk) disable iff (!resetn)
    SEQ_ACCEPT |-> ##3 ramWdata[31] == $past(rxUnmatched, 3) &&
      ramWdata[30:24] == $past(rxFilterIdx, 3))
    else $error("word 1 filter fields wrong");
  AST_W1_MODE: assert property (@(posedge mclk) disable iff (!resetn)
    SEQ_ACCEPT |-> ##3 ramWdata[23:22] == 2'h0 &&
      ramWdata[21] == $past(rxEdl, 3) && ramWdata[20] == $past(rxBrs, 3) &&
      ramWdata[19:16] == $past(rxDlc, 3))
    else $error("word 1 format fields wrong");
  AST_ADDR_STEP: assert property (@(posedge mclk) disable iff (!resetn)
    ramWe && $past(ramWe) |-> ramAddr == $past(ramAddr) + 14'h0001)
    else $error("element words not consecutive");
  AST_DONE_LATE: assert property (@(posedge mclk) disable iff (!resetn)
    elementStored |-> !ramWe && $past(ramWe))
    else $error("stored reported before last write");
  AST_WORD_COUNT: assert property (@(posedge mclk) disable iff (!resetn)
    elementStored |-> wrCount == can_rx_pkg::HEADER_WORDS + lenBus.dataWords)
    else $error("element word count wrong");
endmodule

// ===== include/can_rx_pkg.sv
package can_rx_pkg;
  localparam logic [7:0] OFS_ELEM_SIZE = 8'h00;
  localparam logic [7:0] OFS_BUF_START = 8'h04;
  localparam logic [7:0] OFS_FIFO0_START = 8'h08;
  localparam logic [7:0] OFS_FIFO1_START = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam int ESZ_FIFO0_LSB = 0;
  localparam int ESZ_FIFO1_LSB = 4;
  localparam int ESZ_BUF_LSB = 8;
  localparam logic [2:0] ESZ_RST = 3'h0;
  localparam logic [13:0] START_RST = 14'h0000;
  localparam int START_LSB = 2;

  localparam int ST_BUSY = 0;
  localparam int ST_DROP = 1;
  localparam int ST_DEST_LSB = 4;
  localparam int ST_INDEX_LSB = 8;
  localparam int ST_COUNT_LSB = 16;
  localparam int ST_BYTES_LSB = 24;

  localparam int W0_ESI = 31;
  localparam int W0_EXT_ID = 30;
  localparam int W0_RTR = 29;
  localparam int STD_ID_LSB = 18;
  localparam int W1_UNMATCHED = 31;
  localparam int W1_FILTER_LSB = 24;
  localparam int W1_EDL = 21;
  localparam int W1_BRS = 20;
  localparam int W1_DLC_LSB = 16;

  localparam int NUM_BUFFERS = 64;
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] MAX_DATA_BYTES = 7'h40;
  localparam int MAX_DATA_WORDS = 16;
  localparam logic [4:0] HEADER_WORDS = 5'h02;
  localparam logic [3:0] DLC_DIRECT_MAX = 4'h8;

  // Byte counts for DLC codes 8..15 in FD format, also the element sizes.
  localparam logic [55:0] FD_BYTES = {7'h40, 7'h30, 7'h20, 7'h18,
                                      7'h14, 7'h10, 7'h0c, 7'h08};

  typedef enum logic [1:0] {
    DEST_BUF = 2'b00,
    DEST_FIFO0 = 2'b01,
    DEST_FIFO1 = 2'b10
  } dest_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WORD0 = 2'b01,
    ST_WORD1 = 2'b10,
    ST_DATA = 2'b11
  } pack_state_t;
endpackage

// ===== include/rx_len_if.sv
interface rx_len_if;
  logic [3:0] dlc;
  logic fdFrame;
  logic [2:0] sizeCode;
  logic [6:0] dataBytes;
  logic [4:0] dataWords;
  modport user(output dlc, output fdFrame, output sizeCode,
               input dataBytes, input dataWords);
  modport decoder(input dlc, input fdFrame, input sizeCode,
                  output dataBytes, output dataWords);
endinterface

// ===== src/can_rx_len_decode.sv
module can_rx_len_decode (
  rx_len_if.decoder lenBus
);
  logic [6:0] sizeBytes;

  always_comb begin
    if (lenBus.dlc <= can_rx_pkg::DLC_DIRECT_MAX) begin
      lenBus.dataBytes = {3'h0, lenBus.dlc};
    end else if (lenBus.fdFrame) begin
      lenBus.dataBytes = can_rx_pkg::FD_BYTES[lenBus.dlc[2:0]*7 +: 7];
    end else begin
      lenBus.dataBytes = {3'h0, can_rx_pkg::DLC_DIRECT_MAX};
    end
  end

  // The element size codes walk the same 8..64 byte ladder as FD DLCs.
  always_comb begin
    sizeBytes = can_rx_pkg::FD_BYTES[lenBus.sizeCode*7 +: 7];
    lenBus.dataWords = sizeBytes[6:2];
  end
endmodule

// ===== tb/can_rx_ram_model.sv
// Word-wide message memory as the host sees it after the packer writes it.
module can_rx_ram_model (
  input wire logic mclk,
  input wire logic ramWe,
  input wire logic [13:0] ramAddr,
  input wire logic [31:0] ramWdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:16383];

  always_ff @(posedge mclk) begin
    if (ramWe) begin
      mem[ramAddr] <= ramWdata;
    end
  end
endmodule

// ===== tb/can_rx_element_packer_tb_top.sv
module can_rx_element_packer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, regWrStb, regRdStb, rxSof, rxByteValid, rxAccept;
  logic rxEsi, rxExtendedId, rxRtr, rxR1, rxEdl, rxBrs, rxUnmatched;
  logic ramWe, elementStored, busy;
  logic [7:0] regAddr, rxByte;
  logic [31:0] regWrData, regRdData, ramWdata, rdVal;
  logic [15:0] tsValue;
  logic [28:0] rxId;
  logic [3:0] rxDlc;
  logic [6:0] rxFilterIdx;
  logic [1:0] rxDest, storedDest;
  logic [5:0] rxIndex, storedIndex;
  logic [13:0] ramAddr;
  logic [13:0] startW [3];
  logic [6:0] elemBytes [3];
  int n_mismatch, check_count, cycles;

  can_rx_element_packer i_can_rx_element_packer (
    .mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .rxSof(rxSof), .tsValue(tsValue),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxAccept(rxAccept),
    .rxEsi(rxEsi), .rxExtendedId(rxExtendedId), .rxRtr(rxRtr),
    .rxR1(rxR1),
    .rxId(rxId), .rxEdl(rxEdl), .rxBrs(rxBrs), .rxDlc(rxDlc),
    .rxUnmatched(rxUnmatched), .rxFilterIdx(rxFilterIdx),
    .rxDest(rxDest), .rxIndex(rxIndex), .ramWe(ramWe),
    .ramAddr(ramAddr), .ramWdata(ramWdata),
    .elementStored(elementStored), .storedDest(storedDest),
    .storedIndex(storedIndex), .busy(busy)
  );

  can_rx_ram_model i_can_rx_ram_model (
    .mclk(mclk), .ramWe(ramWe), .ramAddr(ramAddr), .ramWdata(ramWdata)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The run is about 700 cycles; the ceiling leaves wide margin.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge mclk);
    regWrStb <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1 rdVal = regRdData;
  endtask

  function automatic int dlcLen(input logic [3:0] dlc, input logic fd);
    int fdLen [7] = '{12, 16, 20, 24, 32, 48, 64};
    if (dlc <= 4'h8) return int'(dlc);
    if (!fd) return 8;
    return fdLen[dlc - 4'h9];
  endfunction

  task automatic sendFrame(input logic [1:0] dest, input logic [5:0] idx,
                           input logic [3:0] dlc, input logic fd,
                           input logic [28:0] id, input logic [15:0] ts);
    int n, w, k;
    logic [13:0] a;
    logic x;
    x = dlc[2];
    n = dlcLen(dlc, fd);
    @(posedge mclk);
    rxSof <= 1'b1;
    tsValue <= ts;
    @(posedge mclk);
    rxSof <= 1'b0;
    tsValue <= ~ts;
    for (k = 0; k < n; k++) begin
      rxByteValid <= 1'b1;
      rxByte <= 8'(id[7:0] + 8'(k));
      @(posedge mclk);
    end
    rxByteValid <= 1'b0;
    rxAccept <= 1'b1;
    rxEsi <= dlc[1];
    rxExtendedId <= x;
    rxRtr <= ~dlc[0];
    rxR1 <= dlc[0];
    rxId <= id;
    rxEdl <= fd;
    rxBrs <= fd;
    rxDlc <= dlc;
    rxUnmatched <= x;
    rxFilterIdx <= id[6:0];
    rxDest <= dest;
    rxIndex <= idx;
    @(posedge mclk);
    rxAccept <= 1'b0;
    #1 check({31'h0, busy}, 32'h1);
    for (k = 0; k < 40 && elementStored !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    check({31'h0, elementStored}, 32'h1);
    check({31'h0, busy}, 32'h0);
    check({24'h0, storedDest, storedIndex}, {24'h0, dest, idx});
    w = int'(elemBytes[dest]) / 4;
    a = 14'(int'(startW[dest]) + int'(idx) * (w + 2));
    check(i_can_rx_ram_model.mem[a], {dlc[1], x, fd ? dlc[0] : ~dlc[0],
          x ? id : {id[10:0], 18'h0}});
    check(i_can_rx_ram_model.mem[a + 14'h1], {x, id[6:0], 2'b00, fd, fd,
          dlc, ts});
    for (k = 0; k < w * 4 && k < n; k++) begin
      check({24'h0, i_can_rx_ram_model.mem[a + 14'(2 + k / 4)][8 * (k % 4) +: 8]},
            {24'h0, 8'(id[7:0] + 8'(k))});
    end
  endtask

  initial begin
    {resetn, regWrStb, regRdStb, rxSof, rxByteValid, rxAccept} = '0;
    {rxEsi, rxExtendedId, rxRtr, rxR1, rxEdl, rxBrs, rxUnmatched} = '0;
    {regAddr, rxByte, regWrData, tsValue, rxId, rxDlc} = '0;
    {rxFilterIdx, rxDest, rxIndex} = '0;
    startW = '{14'h1000, 14'h0200, 14'h0800};
    elemBytes = '{7'h10, 7'h40, 7'h08};
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    regRead(can_rx_pkg::OFS_ELEM_SIZE);
    check(rdVal, 32'h0);
    regRead(can_rx_pkg::OFS_STATUS);
    check(rdVal, 32'h0);
    regRead(8'h20);
    check(rdVal, 32'h0);
    regWrite(can_rx_pkg::OFS_ELEM_SIZE, 32'h0000_0207);
    regWrite(can_rx_pkg::OFS_BUF_START, 32'h0000_4000);
    regWrite(can_rx_pkg::OFS_FIFO0_START, 32'h0000_0800);
    regWrite(can_rx_pkg::OFS_FIFO1_START, 32'h0000_2000);
    regRead(can_rx_pkg::OFS_ELEM_SIZE);
    check(rdVal, 32'h0000_0207);
    regRead(can_rx_pkg::OFS_BUF_START);
    check(rdVal, 32'h0000_4000);
    regRead(can_rx_pkg::OFS_FIFO1_START);
    check(rdVal, 32'h0000_2000);
    // Every length code in FD format, switching identifier kind every four codes.
    for (int d = 0; d < 16; d++) begin
      sendFrame(2'b01, 6'(d), 4'(d), 1'b1, 29'(29'h1abcde00 + 29'(d * 37)),
                16'(16'h1200 + d));
    end
    sendFrame(2'b00, 6'd63, 4'hc, 1'b0, 29'h000005a5, 16'hbeef);
    sendFrame(2'b10, 6'd5, 4'hf, 1'b0, 29'h15555555, 16'h0001);
    regRead(can_rx_pkg::OFS_STATUS);
    check(rdVal, 32'h0812_0520);
    @(posedge mclk);
    rxAccept <= 1'b1;
    rxDest <= 2'b11;
    @(posedge mclk);
    rxAccept <= 1'b0;
    rxDest <= 2'b00;
    regRead(can_rx_pkg::OFS_STATUS);
    check(rdVal, 32'h0812_0522);
    regWrite(can_rx_pkg::OFS_STATUS, 32'h0000_0002);
    regRead(can_rx_pkg::OFS_STATUS);
    check(rdVal, 32'h0812_0520);
    end_sim();
  end
endmodule
